// ==== include/cbu_pkg.sv ====
// Constants and types of the conditional branch unit
package cbu_pkg;
  localparam int CBU_PC_W = 16;
  localparam int CBU_OFS_W = 7;
  localparam int CBU_SREG_W = 8;
  localparam int CBU_PC_STEP = 1;
  localparam int CBU_BIT_C = 0;
  localparam int CBU_BIT_Z = 1;
  localparam int CBU_BIT_N = 2;
  localparam int CBU_BIT_V = 3;
  localparam int CBU_BIT_S = 4;
  localparam int CBU_BIT_H = 5;
  localparam int CBU_BIT_T = 6;
  localparam int CBU_BIT_I = 7;
  localparam logic [CBU_SREG_W-1:0] CBU_SREG_RST = 8'h00;

  typedef enum logic [3:0] {
    CBU_JUMP_ON_CARRY_ONE = 4'h0,
    CBU_JUMP_ON_CARRY_ZERO = 4'h1,
    CBU_JUMP_UNSIGNED_NOT_LOWER = 4'h2,
    CBU_JUMP_UNSIGNED_LOWER = 4'h3,
    CBU_JUMP_ON_NEGATIVE = 4'h4,
    CBU_JUMP_ON_NONNEGATIVE = 4'h5,
    CBU_JUMP_SIGNED_NOT_LESS = 4'h6,
    CBU_JUMP_SIGNED_LESS = 4'h7,
    CBU_JUMP_ON_HALF_CARRY_ONE = 4'h8,
    CBU_JUMP_ON_HALF_CARRY_ZERO = 4'h9,
    CBU_JUMP_ON_TRANSFER_BIT_ONE = 4'ha
  } cbu_kind_t;

  typedef enum logic [0:0] {
    CBU_RUN = 1'b0,
    CBU_FLUSH = 1'b1
  } cbu_fsm_t;
endpackage

// ==== include/cbu_eval_if.sv ====
// Carrier between the branch sequencer and the condition evaluator
`timescale 1ns/1ns
interface cbu_eval_if #(
  parameter int PC_W = cbu_pkg::CBU_PC_W,
  parameter int OFS_W = cbu_pkg::CBU_OFS_W
);
  cbu_pkg::cbu_kind_t kind;
  logic [cbu_pkg::CBU_SREG_W-1:0] flags;
  logic [PC_W-1:0] pc;
  logic [OFS_W-1:0] offset;
  logic cond;
  logic legal;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] target_pc;

  modport eval (input kind, input flags, input pc, input offset,
                output cond, output legal, output seq_pc, output target_pc);
  modport user (output kind, output flags, output pc, output offset,
                input cond, input legal, input seq_pc, input target_pc);
endinterface

// ==== verilog/cbu_eval.sv ====
// Branch condition test and target address arithmetic
`timescale 1ns/1ns
module cbu_eval #(
  parameter int PC_W = cbu_pkg::CBU_PC_W,
  parameter int OFS_W = cbu_pkg::CBU_OFS_W
) (
  cbu_eval_if.eval bus  // Request fields in, decision out
);
  import cbu_pkg::*;

  logic [PC_W-1:0] ext_ofs;
  logic flag_c;
  logic flag_n;
  logic flag_v;
  logic flag_h;
  logic flag_t;

  assign flag_c = bus.flags[CBU_BIT_C];
  assign flag_n = bus.flags[CBU_BIT_N];
  assign flag_v = bus.flags[CBU_BIT_V];
  assign flag_h = bus.flags[CBU_BIT_H];
  assign flag_t = bus.flags[CBU_BIT_T];

  // Signed word displacement widened to the counter width
  assign ext_ofs = {{(PC_W-OFS_W){bus.offset[OFS_W-1]}}, bus.offset}; // RQ13
  assign bus.seq_pc = bus.pc + PC_W'(CBU_PC_STEP);
  assign bus.target_pc = bus.pc + ext_ofs + PC_W'(CBU_PC_STEP); // RQ13

  always_comb begin
    bus.cond = 1'b0;
    bus.legal = 1'b1;
    unique case (bus.kind)
      CBU_JUMP_ON_CARRY_ONE: bus.cond = flag_c; // RQ1
      CBU_JUMP_UNSIGNED_LOWER: bus.cond = flag_c; // RQ1
      CBU_JUMP_ON_CARRY_ZERO: bus.cond = ~flag_c; // RQ2
      CBU_JUMP_UNSIGNED_NOT_LOWER: bus.cond = ~flag_c; // RQ3
      CBU_JUMP_ON_NEGATIVE: bus.cond = flag_n; // RQ4
      CBU_JUMP_ON_NONNEGATIVE: bus.cond = ~flag_n; // RQ5
      CBU_JUMP_SIGNED_NOT_LESS: bus.cond = ~(flag_n ^ flag_v); // RQ6
      CBU_JUMP_SIGNED_LESS: bus.cond = flag_n ^ flag_v; // RQ7
      CBU_JUMP_ON_HALF_CARRY_ONE: bus.cond = flag_h; // RQ8
      CBU_JUMP_ON_HALF_CARRY_ZERO: bus.cond = ~flag_h; // RQ9
      CBU_JUMP_ON_TRANSFER_BIT_ONE: bus.cond = flag_t; // RQ10
      default: bus.legal = 1'b0;
    endcase
  end
endmodule

// ==== verilog/cbu_top.sv ====
// Conditional relative branch sequencer of the core
// Behaviour
// (RQ1) Carry set or unsigned lower: jump to pc plus k plus one, else fall through.
// (RQ2) Carry clear: jump to pc plus k plus one, else fall through.
// (RQ3) Unsigned same-or-higher acts exactly as the carry-clear branch.
// (RQ4) Negative set: jump to pc plus k plus one, else next instruction.
// (RQ5) Negative clear: jump to pc plus k plus one, else next instruction.
// (RQ6) Signed not-less: jump when negative xor overflow is zero.
// (RQ7) Signed less: jump when negative xor overflow is one.
// (RQ8) Half carry set: jump to pc plus k plus one.
// (RQ9) Half carry clear: jump to pc plus k plus one.
// (RQ10) Transfer bit set: jump to pc plus k plus one.
// (RQ11) No branch alters any status flag; each takes one or two cycles.
// (RQ12) Untaken branch takes one cycle, taken branch two with a flush.
// (RQ13) Offset is a signed word displacement, sign-extended before adding.
`timescale 1ns/1ns
module cbu_top #(
  parameter int PC_W = cbu_pkg::CBU_PC_W,
  parameter int OFS_W = cbu_pkg::CBU_OFS_W
) (
  input wire logic i_sys_clk,  // Core clock
  input wire logic i_nrst,  // Synchronous reset, active low
  input wire logic i_valid,  // Branch request present
  input wire cbu_pkg::cbu_kind_t i_kind,  // Branch kind
  input wire logic [OFS_W-1:0] i_offset,  // Signed displacement k
  input wire logic [PC_W-1:0] i_pc,  // Address of the branch
  input wire logic [cbu_pkg::CBU_SREG_W-1:0] i_sreg,  // Status flags
  output logic o_ready,  // Request may be taken
  output logic o_done,  // Branch finished, one cycle
  output logic o_taken,  // Finished branch jumped
  output logic o_pc_load,  // Load o_pc_next into the counter
  output logic o_flush,  // Drop the prefetched word
  output logic o_illegal,  // Unknown kind code seen
  output logic [PC_W-1:0] o_pc_next,  // Next counter value
  output logic [cbu_pkg::CBU_SREG_W-1:0] o_sreg  // Flags, unchanged
);
  import cbu_pkg::*;

  typedef struct packed {
    cbu_fsm_t fsm;
    logic done;
    logic taken;
    logic pc_load;
    logic flush;
    logic illegal;
    logic [PC_W-1:0] pc_next;
    logic [CBU_SREG_W-1:0] sreg;
  } cbu_state_t;

  cbu_state_t st;
  cbu_state_t next_st;

  cbu_eval_if #(.PC_W(PC_W), .OFS_W(OFS_W)) ev ();

  assign ev.kind = i_kind;
  assign ev.flags = i_sreg;
  assign ev.pc = i_pc;
  assign ev.offset = i_offset;

  cbu_eval #(.PC_W(PC_W), .OFS_W(OFS_W)) u_eval (
    .bus(ev)
  );

  // No request accepted while the jump target is being fetched
  assign o_ready = (st.fsm == CBU_RUN);

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.flush = 1'b0;
    next_st.illegal = 1'b0;
    next_st.pc_load = 1'b0;
    next_st.taken = 1'b0;
    unique case (st.fsm)
      CBU_RUN: begin
        if (i_valid) begin
          next_st.sreg = i_sreg; // RQ11
          if (ev.legal && ev.cond) begin
            next_st.fsm = CBU_FLUSH; // RQ12
            next_st.flush = 1'b1; // RQ12
            next_st.pc_next = ev.target_pc; // RQ1
          end else begin
            next_st.done = 1'b1; // RQ12
            next_st.pc_next = ev.seq_pc; // RQ2
            next_st.illegal = ~ev.legal;
          end
        end
      end
      CBU_FLUSH: begin
        next_st.fsm = CBU_RUN; // RQ11
        next_st.done = 1'b1;
        next_st.taken = 1'b1;
        next_st.pc_load = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_nrst) begin
      st <= '{fsm: CBU_RUN, done: 1'b0, taken: 1'b0, pc_load: 1'b0, flush: 1'b0,
              illegal: 1'b0, pc_next: '0, sreg: CBU_SREG_RST};
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
  assign o_taken = st.taken;
  assign o_pc_load = st.pc_load;
  assign o_flush = st.flush;
  assign o_illegal = st.illegal;
  assign o_pc_next = st.pc_next;
  assign o_sreg = st.sreg;
endmodule

// ==== bench/cbu_top_assertions.sv ====
// Checker for the branch unit ports
`timescale 1ns/1ns
module cbu_top_assertions #(
  parameter int PC_W = 16,
  parameter int OFS_W = 7
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic i_valid, // Request
  input wire cbu_pkg::cbu_kind_t i_kind, // Kind
  input wire logic [OFS_W-1:0] i_offset, // Offset
  input wire logic [PC_W-1:0] i_pc, // Address
  input wire logic [cbu_pkg::CBU_SREG_W-1:0] i_sreg, // Flags
  input wire logic o_ready, // Ready
  input wire logic o_done, // Done
  input wire logic o_taken, // Taken
  input wire logic o_pc_load, // Load
  input wire logic o_flush, // Flush
  input wire logic o_illegal, // Illegal
  input wire logic [PC_W-1:0] o_pc_next, // Next pc
  input wire logic [cbu_pkg::CBU_SREG_W-1:0] o_sreg // Flags out
);
  import cbu_pkg::*;
  logic [7:0] s;
  logic nv;
  logic bad;
  logic want;
  logic [10:0] t;
  logic [PC_W-1:0] ofs_x;
  assign s = i_sreg;
  assign nv = s[2] ^ s[3];
  assign t = {s[6], !s[5], s[5], nv, !nv, !s[2], s[2], s[0], !s[0], !s[0], s[0]};
  assign bad = i_kind > 4'ha;
  assign want = bad ? 1'b0 : t[i_kind];
  assign ofs_x = PC_W'($signed(i_offset));
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_acc; i_valid && o_ready; endsequence
  sequence s_jump; o_flush ##1 o_done && o_taken && o_pc_load; endsequence
  sequence s_fall; s_acc ##1 !o_flush; endsequence
  sequence s_hit; s_acc ##1 o_flush; endsequence
  a_cond_flush: assert property (s_acc |=> o_flush == $past(want))
    else $error("condition");
  a_jump_steps: assert property (o_flush |-> s_jump)
    else $error("jump steps");
  a_fall_pc: assert property (s_fall |-> o_done && o_pc_next == $past(i_pc) + 1'b1)
    else $error("fall pc");
  a_jump_pc: assert property (s_hit |-> o_pc_next == $past(i_pc) + $past(ofs_x) + 1'b1)
    else $error("jump pc");
  a_flag_copy: assert property (s_acc |=> o_sreg == $past(i_sreg))
    else $error("flags");
  a_ready_flush: assert property (o_ready != o_flush)
    else $error("ready");
  a_illegal_kind: assert property (i_valid && o_ready && bad |=> o_illegal && o_done)
    else $error("illegal");
  a_illegal_idle: assert property (o_illegal |-> !o_taken && !o_pc_load)
    else $error("illegal jumped");
  a_taken_load: assert property (o_done |-> o_taken == o_pc_load)
    else $error("load");
endmodule
bind cbu_top cbu_top_assertions #(.PC_W(PC_W), .OFS_W(OFS_W)) u_chk (.*);

// ==== bench/tb_cbu_top.sv ====
// Self-checking bench of the branch unit
`timescale 1ns/1ns
module tb_cbu_top;
  import cbu_pkg::*;
  logic i_sys_clk = 0, i_nrst = 0, i_valid = 0;
  cbu_kind_t i_kind = CBU_JUMP_ON_CARRY_ONE;
  logic [6:0] i_offset = 0;
  logic [15:0] i_pc = 0, o_pc_next;
  logic [7:0] i_sreg = 0, o_sreg;
  logic o_ready, o_done, o_taken, o_pc_load, o_flush, o_illegal;
  int num_errors = 0, samples_checked = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  cbu_top dut (.*);
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task summarize;
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task br(input logic [3:0] k, input logic [7:0] f, input logic [15:0] pc, input logic [6:0] o);
    logic nv, w;
    logic [10:0] t;
    nv = f[2] ^ f[3];
    t = {f[6], !f[5], f[5], nv, !nv, !f[2], f[2], f[0], !f[0], !f[0], f[0]};
    w = (k > 4'ha) ? 1'b0 : t[k];
    @(posedge i_sys_clk) #1;
    i_valid = 1;
    i_kind = cbu_kind_t'(k);
    i_sreg = f;
    i_pc = pc;
    i_offset = o;
    @(posedge i_sys_clk) #1;
    i_valid = 0;
    chk(o_flush, w);
    chk(o_ready, !w);
    chk(o_illegal, k > 4'ha);
    if (w) @(posedge i_sys_clk) #1;
    chk(o_done, 1);
    chk(o_taken, w);
    chk(o_pc_next, w ? pc + {{9{o[6]}}, o} + 16'h1 : pc + 16'h1);
    chk(o_sreg, f);
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1 i_nrst = 1;
    for (int k = 0; k < 12; k++) begin
      br(4'(k), 8'h00, 16'hffff, 7'h3f);
      br(4'(k), 8'hff, 16'h0010, 7'h40);
      br(4'(k), 8'h04, 16'h0200, 7'h01);
    end
    // Request held through the flush cycle waits for the done edge
    @(posedge i_sys_clk) #1;
    i_valid = 1;
    i_kind = CBU_JUMP_ON_CARRY_ONE;
    i_sreg = 8'h01;
    i_pc = 16'h0100;
    i_offset = 7'h02;
    @(posedge i_sys_clk) #1;
    chk(o_ready, 0);
    chk(o_flush, 1);
    i_kind = CBU_JUMP_ON_CARRY_ZERO;
    i_pc = 16'h0300;
    @(posedge i_sys_clk) #1;
    chk(o_done, 1);
    chk(o_taken, 1);
    chk(o_pc_next, 16'h0103);
    @(posedge i_sys_clk) #1;
    i_valid = 0;
    chk(o_done, 1);
    chk(o_taken, 0);
    chk(o_pc_next, 16'h0301);
    chk(o_sreg, 8'h01);
    summarize();
  end
  initial begin
    repeat (1000) @(posedge i_sys_clk);
    num_errors++;
    summarize();
  end
endmodule
